// ==== design/sam_pkg.sv ====
// Shared constants and state types for the receive-side alarm monitor
package sam_pkg;
    // Clock and loss-of-frame timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned LOF_TIME_NS = 3000000;
    localparam int unsigned LOF_CYC = (LOF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOF_TW = 16;

    // Alarm vector layout
    localparam int unsigned NUM_ALM = 9;
    localparam int unsigned ALM_LOS = 0;
    localparam int unsigned ALM_LOF = 1;
    localparam int unsigned ALM_OOF = 2;
    localparam int unsigned ALM_LFERF = 3;
    localparam int unsigned ALM_LAIS = 4;
    localparam int unsigned ALM_PFERF = 5;
    localparam int unsigned ALM_PAIS = 6;
    localparam int unsigned ALM_PYEL = 7;
    localparam int unsigned ALM_PLOP = 8;

    // Register map, byte addresses
    localparam logic [7:0] REG_CUR = 8'h00;
    localparam logic [7:0] REG_HIST = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0c;
    localparam logic [7:0] REG_ERRCNT = 8'h10;
    localparam int unsigned CMD_HCLR = 0;
    localparam int unsigned CMD_CCLR = 1;
    localparam logic [8:0] RST_MASK = 9'h1ff;

    // Overhead byte patterns and fields
    localparam logic [2:0] K2_FERF = 3'h6;
    localparam logic [2:0] K2_AIS = 3'h7;
    localparam logic [3:0] G1_FERF = 4'h9;
    localparam int unsigned G1_YEL_BIT = 3;
    localparam logic [9:0] PTR_MAX = 10'h30e;

    // Frame persistence counts
    localparam logic [3:0] OOF_SET = 4'h4;
    localparam logic [3:0] OOF_CLR = 4'h2;
    localparam logic [3:0] K2_CNT = 4'h5;
    localparam logic [3:0] PFERF_CNT = 4'h2;
    localparam logic [3:0] PAIS_CNT = 4'h3;
    localparam logic [3:0] YEL_CNT = 4'h5;
    localparam logic [3:0] LOP_SET = 4'h8;
    localparam logic [3:0] LOP_CLR = 4'h3;

    typedef struct packed {
        logic active;
        logic [3:0] cnt;
    } sam_pst_t;

    typedef struct packed {
        logic sig_s1;
        logic sig_s2;
        logic lof;
        logic [LOF_TW-1:0] lof_tmr;
        logic [NUM_ALM-1:0] cur;
        logic [NUM_ALM-1:0] hist;
        logic [NUM_ALM-1:0] mask;
        logic [15:0] errcnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sam_st_t;
endpackage

// ==== design/sam_alarm_monitor.sv ====
// Receive-side section, line and path alarm monitor with APB register access
// Operation
// - Raise section loss of signal while no optical input is detected.
// - Declare loss of frame after out-of-frame persists three milliseconds.
// - Loss of frame stays until in-frame persists three milliseconds.
// - Declare out-of-frame after four consecutive frames with framing errors.
// - Remove out-of-frame after two consecutive correctly framed frames.
// - Declare line far-end failure when K2 bits 6-8 are 110 five frames.
// - Clear line far-end failure after five frames with other K2 value.
// - Declare line AIS when K2 bits 6-8 are 111 five frames.
// - Clear line AIS after five frames with other K2 value.
// - Declare path far-end failure when G1 field is 1001 two frames.
// - Clear path far-end failure after two frames with other G1 value.
// - Declare path AIS when H1 and H2 are all ones three frames.
// - Clear path AIS after a valid pointer in three frames.
// - Declare path yellow when G1 bit 5 is one five frames.
// - Clear path yellow after G1 bit 5 is zero five frames.
// - Declare loss of pointer when no normal pointer in eight frames.
// - Clear loss of pointer after a valid pointer in three frames.
// - An all-ones pointer never counts toward loss of pointer.
// - Justification indications count as valid pointers unless H1 and H2 are all ones.
// - Each alarm has a current and a history indicator.
// - History clear command resets every history indicator except those of alarms current in the clear cycle, which stay set.
// - Counter clear command resets the counter of frames with framing errors.
`timescale 1ns/100ps

module sam_persist #(
    parameter logic [3:0] P_SET = 4'h4,
    parameter logic [3:0] P_CLR = 4'h2
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_stb,
    input wire logic i_set_cond,
    input wire logic i_clr_cond,
    output logic o_active
);
    import sam_pkg::*;

    sam_pst_t q;
    sam_pst_t d;

    // A frame that breaks the run restarts the count from zero
    always_comb begin
        d = q;
        if (i_stb) begin
            if (!q.active) begin
                if (!i_set_cond) begin
                    d.cnt = 4'h0;
                end else if (q.cnt == P_SET - 4'h1) begin
                    d.active = 1'b1;
                    d.cnt = 4'h0;
                end else begin
                    d.cnt = q.cnt + 4'h1;
                end
            end else begin
                if (!i_clr_cond) begin
                    d.cnt = 4'h0;
                end else if (q.cnt == P_CLR - 4'h1) begin
                    d.active = 1'b0;
                    d.cnt = 4'h0;
                end else begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_active = q.active;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    a_set_run: assert property ($rose(q.active) |->
        $past(q.cnt) == P_SET - 4'h1 && $past(i_stb) && $past(i_set_cond))
        else $error("alarm declared without a full run of frames");

    a_clr_run: assert property ($fell(q.active) |->
        $past(q.cnt) == P_CLR - 4'h1 && $past(i_stb) && $past(i_clr_cond))
        else $error("alarm removed without a full run of frames");
endmodule // sam_persist

module sam_alarm_monitor #(
    parameter logic [sam_pkg::LOF_TW-1:0] P_LOF_CYC = sam_pkg::LOF_TW'(sam_pkg::LOF_CYC)
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sig_present,
    input wire logic i_frm_stb,
    input wire logic i_frm_err,
    input wire logic [7:0] i_k2,
    input wire logic [7:0] i_g1,
    input wire logic [7:0] i_h1,
    input wire logic [7:0] i_h2,
    input wire logic i_ptr_just,
    output logic [sam_pkg::NUM_ALM-1:0] o_alarm_cur,
    output logic [sam_pkg::NUM_ALM-1:0] o_alarm_hist,
    output logic [15:0] o_err_frames
);
    import sam_pkg::*;

    sam_st_t q;
    sam_st_t d;
    logic oof;
    logic lferf;
    logic lais;
    logic pferf;
    logic pais;
    logic pyel;
    logic plop;
    logic ptr_ones;
    logic ptr_valid;
    logic acc_first;
    logic wr;
    logic hclr;
    logic cclr;
    logic [NUM_ALM-1:0] act;

    assign ptr_ones = (i_h1 == 8'hff) && (i_h2 == 8'hff);
    // Stuffed frames invert pointer bits, so the framer flags them instead
    assign ptr_valid = !ptr_ones && (({i_h1[1:0], i_h2} <= PTR_MAX) || i_ptr_just);

    // APB: one wait state; the write lands at the edge where pready is sampled high
    assign acc_first = i_psel && i_penable && !q.pready;
    assign wr = i_psel && i_penable && q.pready && i_pwrite;
    assign hclr = wr && (i_paddr == REG_CMD) && i_pwdata[CMD_HCLR];
    assign cclr = wr && (i_paddr == REG_CMD) && i_pwdata[CMD_CCLR];

    sam_persist #(.P_SET(OOF_SET), .P_CLR(OOF_CLR)) u_oof (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(i_frm_err),
        .i_clr_cond(!i_frm_err),
        .o_active(oof)
    );

    sam_persist #(.P_SET(K2_CNT), .P_CLR(K2_CNT)) u_lferf (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(i_k2[2:0] == K2_FERF),
        .i_clr_cond(i_k2[2:0] != K2_FERF),
        .o_active(lferf)
    );

    sam_persist #(.P_SET(K2_CNT), .P_CLR(K2_CNT)) u_lais (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(i_k2[2:0] == K2_AIS),
        .i_clr_cond(i_k2[2:0] != K2_AIS),
        .o_active(lais)
    );

    sam_persist #(.P_SET(PFERF_CNT), .P_CLR(PFERF_CNT)) u_pferf (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(i_g1[7:4] == G1_FERF),
        .i_clr_cond(i_g1[7:4] != G1_FERF),
        .o_active(pferf)
    );

    sam_persist #(.P_SET(PAIS_CNT), .P_CLR(PAIS_CNT)) u_pais (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(ptr_ones),
        .i_clr_cond(ptr_valid),
        .o_active(pais)
    );

    sam_persist #(.P_SET(YEL_CNT), .P_CLR(YEL_CNT)) u_pyel (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(i_g1[G1_YEL_BIT]),
        .i_clr_cond(!i_g1[G1_YEL_BIT]),
        .o_active(pyel)
    );

    // An all-ones frame breaks the missing-pointer run rather than extending it
    sam_persist #(.P_SET(LOP_SET), .P_CLR(LOP_CLR)) u_plop (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_stb(i_frm_stb),
        .i_set_cond(!ptr_valid && !ptr_ones),
        .i_clr_cond(ptr_valid),
        .o_active(plop)
    );

    always_comb begin
        d = q;
        d.sig_s1 = i_sig_present;
        d.sig_s2 = q.sig_s1;

        // Timer runs only while the frame state disagrees with the lof flag
        if (q.lof == oof) begin
            d.lof_tmr = '0;
        end else if (q.lof_tmr == P_LOF_CYC - 1'b1) begin
            d.lof = !q.lof;
            d.lof_tmr = '0;
        end else begin
            d.lof_tmr = q.lof_tmr + 1'b1;
        end

        act = '0;
        act[ALM_LOS] = !q.sig_s2;
        act[ALM_LOF] = q.lof;
        act[ALM_OOF] = oof;
        act[ALM_LFERF] = lferf;
        act[ALM_LAIS] = lais;
        act[ALM_PFERF] = pferf;
        act[ALM_PAIS] = pais;
        act[ALM_PYEL] = pyel;
        act[ALM_PLOP] = plop;
        d.cur = act & q.mask;
        // A live alarm in the clear cycle survives the clear
        d.hist = (hclr ? '0 : q.hist) | q.cur;

        d.errcnt = cclr ? 16'h0 : q.errcnt;
        if (i_frm_stb && i_frm_err && d.errcnt != 16'hffff) begin
            d.errcnt = d.errcnt + 16'h1;
        end

        d.pready = acc_first;
        d.pslverr = 1'b0;
        d.prdata = '0;
        if (acc_first) begin
            case (i_paddr)
                REG_CUR: d.prdata = {23'h0, q.cur};
                REG_HIST: d.prdata = {23'h0, q.hist};
                REG_MASK: d.prdata = {23'h0, q.mask};
                REG_CMD: d.prdata = 32'h0;
                REG_ERRCNT: d.prdata = {16'h0, q.errcnt};
                default: d.pslverr = 1'b1;
            endcase
        end
        if (wr && i_paddr == REG_MASK) begin
            d.mask = i_pwdata[NUM_ALM-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.mask <= RST_MASK;
            // Synchroniser starts at signal present so no false loss of signal follows reset
            q.sig_s1 <= 1'b1;
            q.sig_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_alarm_cur = q.cur;
    assign o_alarm_hist = q.hist;
    assign o_err_frames = q.errcnt;
    assign o_prdata = q.prdata;
    assign o_pready = q.pready;
    assign o_pslverr = q.pslverr;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    a_los_tracks_pin: assert property (!q.sig_s2 && q.mask[ALM_LOS] |=>
        o_alarm_cur[ALM_LOS])
        else $error("loss of signal not shown while input absent");

    a_lof_declare: assert property ($rose(q.lof) |->
        $past(q.lof_tmr) == P_LOF_CYC - 1'b1 && $past(oof))
        else $error("loss of frame declared before full timer");

    a_lof_release: assert property ($fell(q.lof) |->
        $past(q.lof_tmr) == P_LOF_CYC - 1'b1 && !$past(oof))
        else $error("loss of frame removed before full timer");

    a_lop_ais_hold: assert property (i_frm_stb && ptr_ones && !plop |=>
        !plop)
        else $error("all-ones pointer raised loss of pointer");

    a_hist_latch: assert property (|o_alarm_cur |=>
        (o_alarm_hist & $past(o_alarm_cur)) == $past(o_alarm_cur))
        else $error("history failed to latch current alarm");

    a_hist_clear: assert property (hclr |=>
        o_alarm_hist == $past(o_alarm_cur))
        else $error("history not cleared by command");

    a_cnt_clear: assert property (cclr |=> o_err_frames <= 16'h1)
        else $error("error counter not cleared by command");

    a_apb_wait: assert property (acc_first |=> o_pready ##1 !o_pready)
        else $error("apb answer not exactly one wait state");

    c_oof_seen: cover property ($rose(oof));
    c_lof_seen: cover property ($rose(q.lof));
    c_lop_seen: cover property ($rose(plop));
    c_hist_cleared: cover property (hclr && |q.hist);
endmodule // sam_alarm_monitor

// ==== tb/sam_line_model.sv ====
// Behavioural receive line and framer that hands frames to the monitor
`timescale 1ns/100ps
module sam_line_model (
    input wire logic i_clk_sys,
    output logic o_sig_present,
    output logic o_frm_stb,
    output logic [33:0] o_frm
);
    initial begin
        o_sig_present = 1'b1;
        o_frm_stb = 1'b0;
        o_frm = '0;
    end
    task automatic set_sig(input logic s);
        @(posedge i_clk_sys);
        o_sig_present <= s;
    endtask
    // Overhead lines flip after the strobe so stale bytes never pass for a frame
    task automatic send(input logic [33:0] f);
        @(posedge i_clk_sys);
        o_frm_stb <= 1'b1;
        o_frm <= f;
        @(posedge i_clk_sys);
        o_frm_stb <= 1'b0;
        o_frm <= ~f;
    endtask
endmodule // sam_line_model

// ==== tb/sam_alarm_monitor_tb.sv ====
// Self-checking bench for the alarm monitor with a frame-level reference model
`timescale 1ns/100ps
module sam_alarm_monitor_tb;
    import sam_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, re, sig, stb;
    logic [33:0] fr, f;
    logic [8:0] cur, hist, m_act, m_mask, m_hist;
    logic [15:0] errs;
    int err_count, n_checks, cyc, n_err, pk;
    int sc[9], cc[9];

    always #50 clk = ~clk;

    sam_line_model u_line (.i_clk_sys(clk), .o_sig_present(sig), .o_frm_stb(stb), .o_frm(fr));
    // Short loss-of-frame time keeps the run brief
    sam_alarm_monitor #(.P_LOF_CYC(16'h0014)) u_dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sig_present(sig), .i_frm_stb(stb),
        .i_frm_err(fr[33]), .i_k2(fr[32:25]), .i_g1(fr[24:17]), .i_h1(fr[16:9]),
        .i_h2(fr[8:1]), .i_ptr_just(fr[0]), .o_alarm_cur(cur), .o_alarm_hist(hist),
        .o_err_frames(errs)
    );

    task automatic end_sim();
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check();
        chk("cur", 32'(cur), 32'(m_act & m_mask));
        chk("errs", 32'(errs), 32'(n_err));
        // History takes in the current alarms one cycle after they show
        @(posedge clk);
        #10;
        m_hist = m_hist | (m_act & m_mask);
        chk("hist", 32'(hist), 32'(m_hist));
    endtask
    task automatic pers(input int i, input bit s, input bit c, input int ns, input int nc);
        sc[i] = s ? sc[i] + 1 : 0;
        cc[i] = c ? cc[i] + 1 : 0;
        if (sc[i] >= ns) m_act[i] = 1'b1;
        if (cc[i] >= nc) m_act[i] = 1'b0;
    endtask
    // Reference update per frame: {err, k2, g1, h1, h2, justification}
    task automatic frame(input logic [33:0] x);
        bit ones, vld;
        ones = &x[16:1];
        vld = !ones && (x[10:1] <= PTR_MAX || x[0]);
        u_line.send(x);
        pers(ALM_OOF, x[33], !x[33], OOF_SET, OOF_CLR);
        pers(ALM_LFERF, x[27:25] == K2_FERF, x[27:25] != K2_FERF, K2_CNT, K2_CNT);
        pers(ALM_LAIS, x[27:25] == K2_AIS, x[27:25] != K2_AIS, K2_CNT, K2_CNT);
        pers(ALM_PFERF, x[24:21] == G1_FERF, x[24:21] != G1_FERF, PFERF_CNT, PFERF_CNT);
        pers(ALM_PAIS, ones, vld, PAIS_CNT, PAIS_CNT);
        pers(ALM_PYEL, x[20], !x[20], YEL_CNT, YEL_CNT);
        pers(ALM_PLOP, !ones && !vld, vld, LOP_SET, LOP_CLR);
        if (x[33] && n_err < 65535) n_err++;
        @(posedge clk);
        #10;
        check();
    endtask

    initial begin
        void'($urandom(48));
        m_act = '0;
        m_hist = '0;
        m_mask = RST_MASK;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #10;
        check();
        apb(1'b0, REG_MASK, '0);
        chk("mask", rd, 32'h000001ff);
        apb(1'b0, 8'h20, '0);
        chk("slverr", 32'(re), 32'h00000001);
        u_line.set_sig(1'b0);
        repeat (6) @(posedge clk);
        #10;
        m_act[ALM_LOS] = 1'b1;
        check();
        u_line.set_sig(1'b1);
        repeat (6) @(posedge clk);
        #10;
        m_act[ALM_LOS] = 1'b0;
        check();
        // Loss of frame is hidden during random traffic; its timing is tested alone below
        apb(1'b1, REG_MASK, 32'h000001fd);
        m_mask = 9'h1fd;
        repeat (150) begin
            pk = $urandom % 4;
            f[33] = 1'($urandom % 2);
            f[32:28] = 5'($urandom);
            f[27:25] = ($urandom % 3 == 0) ? 3'($urandom) : 3'(6 + $urandom % 2);
            f[24:21] = ($urandom % 2) ? G1_FERF : 4'($urandom);
            f[20:17] = 4'($urandom);
            f[16:11] = 6'($urandom % 63);
            f[10:1] = (pk < 2) ? 10'($urandom % 783) : 10'(783 + $urandom % 241);
            if (pk == 0) f[16:1] = 16'hffff;
            f[0] = (pk == 3);
            repeat ($urandom % 10 + 1) frame(f);
        end
        apb(1'b0, REG_CUR, '0);
        chk("rd cur", rd, 32'(m_act & m_mask));
        apb(1'b1, REG_CMD, 32'h00000001);
        #10;
        m_hist = m_act & m_mask;
        check();
        apb(1'b1, REG_CMD, 32'h00000002);
        n_err = 0;
        #10;
        check();
        apb(1'b0, REG_ERRCNT, '0);
        chk("rd errs", rd, 32'h00000000);
        repeat (2) frame('0);
        repeat (40) @(posedge clk);
        apb(1'b1, REG_MASK, 32'h000001ff);
        m_mask = 9'h1ff;
        repeat (4) frame(34'h200000000);
        repeat (30) @(posedge clk);
        #10;
        m_act[ALM_LOF] = 1'b1;
        check();
        repeat (2) frame('0);
        repeat (8) @(posedge clk);
        #10;
        check();
        repeat (30) @(posedge clk);
        #10;
        m_act[ALM_LOF] = 1'b0;
        check();
        end_sim();
    end
endmodule // sam_alarm_monitor_tb
